// [shared/mcpi_pkg.sv]
// Package: constants and types for the memory card pin interface
package mcpi_pkg;

  localparam int unsigned NUM_PORTS      = 2;
  localparam int unsigned DATA_W         = 4;
  localparam int unsigned CLK_DIV_W      = 8;
  localparam int unsigned SYNC_STAGES    = 2;

  // Status word layout, one pair of bits per socket
  localparam int unsigned STAT_PRESENT_BIT = 0;
  localparam int unsigned STAT_WPROT_BIT   = 1;
  localparam int unsigned STAT_BITS        = 2;
  localparam int unsigned STAT_W           = NUM_PORTS * STAT_BITS;

  localparam logic [STAT_W-1:0] STAT_RESET = 4'h0;

  // Card clock divider: half period minus one, in ref_clk cycles
  localparam logic [CLK_DIV_W-1:0] CLK_HALF_DEFAULT = 8'h04;

  typedef enum logic [1:0] {
    MCPI_IDLE = 2'b00,
    MCPI_MMC  = 2'b01,
    MCPI_WIDE = 2'b10
  } mcpi_mode_t;

  typedef enum logic [1:0] {
    MCPI_CARD_NONE = 2'b00,
    MCPI_CARD_MMC  = 2'b01,
    MCPI_CARD_SD   = 2'b10
  } mcpi_card_t;

endpackage : mcpi_pkg

// [logic/mcpi_port.sv]
// One card socket: mode control, pin steering and socket sense
`timescale 1ns/1ps
module mcpi_port (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic                           power_req,
  input  wire logic                           wide_req,
  input  wire logic                           id_valid,
  input  wire mcpi_pkg::mcpi_card_t           id_type,
  input  wire logic                           sel_active,
  input  wire logic [mcpi_pkg::CLK_DIV_W-1:0] clk_half,
  input  wire logic                           cmd_out,
  input  wire logic                           cmd_drive,
  output logic                                cmd_in,
  input  wire logic [mcpi_pkg::DATA_W-1:0]    data_out,
  input  wire logic                           data_drive,
  output logic [mcpi_pkg::DATA_W-1:0]         data_in,
  output logic                                wide_active,
  output logic                                present,
  output logic                                wprot,
  output logic                                card_clock_out,
  output logic                                card_power_enable,
  output logic                                card_cmd_line_o,
  output logic                                card_cmd_line_oe_n,
  input  wire logic                           card_cmd_line_i,
  output logic [mcpi_pkg::DATA_W-1:0]         card_data_bus_o,
  output logic [mcpi_pkg::DATA_W-1:0]         card_data_bus_oe_n,
  input  wire logic [mcpi_pkg::DATA_W-1:0]    card_data_bus_i,
  input  wire logic                           card_present_n,
  input  wire logic                           write_protect_sense
);

  // ----------------------------------------
  // Mode state
  // ----------------------------------------
  mcpi_pkg::mcpi_mode_t            mode_reg;
  mcpi_pkg::mcpi_mode_t            mode_next;
  mcpi_pkg::mcpi_card_t            card_reg;
  mcpi_pkg::mcpi_card_t            card_next;

  always_comb begin
    mode_next = mode_reg;
    card_next = card_reg;
    if (!present || !power_req) begin
      mode_next = mcpi_pkg::MCPI_IDLE;
      card_next = mcpi_pkg::MCPI_CARD_NONE;
    end else begin
      if (id_valid) begin
        card_next = id_type;
      end
      unique case (mode_reg)
        mcpi_pkg::MCPI_IDLE: begin
          mode_next = mcpi_pkg::MCPI_MMC; // [R2]
        end
        mcpi_pkg::MCPI_MMC: begin
          if (wide_req && card_next == mcpi_pkg::MCPI_CARD_SD) begin
            mode_next = mcpi_pkg::MCPI_WIDE; // [R3] [R11]
          end
        end
        mcpi_pkg::MCPI_WIDE: begin
          if (!wide_req || card_next != mcpi_pkg::MCPI_CARD_SD) begin
            mode_next = mcpi_pkg::MCPI_MMC; // [R11]
          end
        end
        default: begin
          mode_next = mcpi_pkg::MCPI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= mcpi_pkg::MCPI_IDLE;
      card_reg <= mcpi_pkg::MCPI_CARD_NONE;
    end else begin
      mode_reg <= mode_next;
      card_reg <= card_next;
    end
  end

  // ----------------------------------------
  // Card clock and socket sense
  // ----------------------------------------
  logic [mcpi_pkg::CLK_DIV_W-1:0]  div_reg;
  logic [mcpi_pkg::CLK_DIV_W-1:0]  div_next;
  logic                            cclk_reg;
  logic                            cclk_next;
  logic                            pres_reg;
  logic                            pres_next;
  logic                            wp_reg;
  logic                            wp_next;
  logic                            pwr_reg;
  logic                            pwr_next;

  always_comb begin
    div_next  = div_reg;
    cclk_next = 1'b0;
    if (mode_reg != mcpi_pkg::MCPI_IDLE) begin
      cclk_next = cclk_reg;
      if (div_reg >= clk_half) begin
        div_next  = '0;
        cclk_next = ~cclk_reg; // [R10]
      end else begin
        div_next = div_reg + 8'h01;
      end
    end else begin
      div_next = '0;
    end
    pres_next = ~card_present_n;   // [R5] [R6]
    wp_next   = write_protect_sense; // [R6]
    pwr_next  = power_req;         // [R9]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_reg  <= '0;
      cclk_reg <= 1'b0;
      pres_reg <= 1'b0;
      wp_reg   <= 1'b0;
      pwr_reg  <= 1'b0;
    end else begin
      div_reg  <= div_next;
      cclk_reg <= cclk_next;
      pres_reg <= pres_next;
      wp_reg   <= wp_next;
      pwr_reg  <= pwr_next;
    end
  end

  // ----------------------------------------
  // Pin steering
  // ----------------------------------------
  always_comb begin
    wide_active        = (mode_reg == mcpi_pkg::MCPI_WIDE);
    present            = pres_reg;
    wprot              = wp_reg;
    card_clock_out     = cclk_reg;           // [R10]
    card_power_enable  = pwr_reg;            // [R9]
    card_cmd_line_o    = cmd_out;            // [R10]
    card_cmd_line_oe_n = ~(cmd_drive && mode_reg != mcpi_pkg::MCPI_IDLE);
    cmd_in             = card_cmd_line_i;
    card_data_bus_o    = '0;
    card_data_bus_oe_n = '1;
    data_in            = '0;
    unique case (mode_reg)
      mcpi_pkg::MCPI_WIDE: begin
        card_data_bus_o    = data_out;       // [R3]
        card_data_bus_oe_n = {mcpi_pkg::DATA_W{~data_drive}};
        data_in            = card_data_bus_i;
      end
      mcpi_pkg::MCPI_MMC: begin
        // Line 3 is chip select, line 0 sole data, 1 and 2 idle
        card_data_bus_o[3]    = ~sel_active;   // [R4]
        card_data_bus_oe_n[3] = 1'b0;          // [R4]
        card_data_bus_o[0]    = data_out[0];   // [R4]
        card_data_bus_oe_n[0] = ~data_drive;
        data_in[0]            = card_data_bus_i[0];
      end
      default: begin
      end
    endcase
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_wide_sd_only: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == mcpi_pkg::MCPI_WIDE |-> card_reg == mcpi_pkg::MCPI_CARD_SD)
    else $error("wide mode without SD card"); // [R3]
  a_mmc_default: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == mcpi_pkg::MCPI_IDLE && present && power_req
    |=> mode_reg == mcpi_pkg::MCPI_MMC)
    else $error("card not started in MMC mode"); // [R2]
  a_mmc_lines_idle: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == mcpi_pkg::MCPI_MMC |-> card_data_bus_oe_n[2:1] == 2'h3
    && card_data_bus_oe_n[3] == 1'b0 && card_data_bus_o[3] == !sel_active)
    else $error("MMC line use wrong"); // [R4]
  a_present_low: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 present == !$past(card_present_n))
    else $error("presence not active low"); // [R5]
  a_wprot_follow: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 wprot == $past(write_protect_sense))
    else $error("write protect not followed"); // [R6]
  a_power_follow: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(power_req) |=> card_power_enable)
    else $error("power enable late"); // [R9]
  a_mmc_stays: assert property (@(posedge ref_clk) disable iff (rst)
    card_reg == mcpi_pkg::MCPI_CARD_MMC && mode_reg == mcpi_pkg::MCPI_MMC
    && !id_valid |=> mode_reg != mcpi_pkg::MCPI_WIDE)
    else $error("MMC card left single line mode"); // [R11]
  a_clock_idle: assert property (@(posedge ref_clk) disable iff (rst)
    mode_reg == mcpi_pkg::MCPI_IDLE [*2] |-> !card_clock_out)
    else $error("card clock runs with no card"); // [R10]

endmodule // mcpi_port

// [logic/mcpi_top.sv]
// Top: two card sockets and their shared status word
//
// Contract
// (R1) Two independent sockets, each MMC or SD
// (R2) New cards start in MMC mode
// (R3) Four-bit mode only for SD cards
// (R4) MMC: line 3 select, line 0 data
// (R5) Card presence input is active low
// (R6) Socket switches give presence and write protect
// (R7) Presence levels readable in status word
// (R8) Write-protect levels readable in same word
// (R9) Power enable switches card supply
// (R10) Host drives clock, command goes both ways
// (R11) Wide mode only after SD identified
`timescale 1ns/1ps
module mcpi_top (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       power_req,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       wide_req,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       id_valid,
  input  wire logic [2*mcpi_pkg::NUM_PORTS-1:0]     id_type,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       sel_active,
  input  wire logic [mcpi_pkg::CLK_DIV_W-1:0]       clk_half,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       cmd_out,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       cmd_drive,
  output logic [mcpi_pkg::NUM_PORTS-1:0]            cmd_in,
  input  wire logic [mcpi_pkg::NUM_PORTS*4-1:0]     data_out,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       data_drive,
  output logic [mcpi_pkg::NUM_PORTS*4-1:0]          data_in,
  output logic [mcpi_pkg::NUM_PORTS-1:0]            wide_active,
  output logic [mcpi_pkg::STAT_W-1:0]               sys_card_status_reg,
  output logic [mcpi_pkg::NUM_PORTS-1:0]            card_clock_out,
  output logic [mcpi_pkg::NUM_PORTS-1:0]            card_power_enable,
  output logic [mcpi_pkg::NUM_PORTS-1:0]            card_cmd_line_o,
  output logic [mcpi_pkg::NUM_PORTS-1:0]            card_cmd_line_oe_n,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       card_cmd_line_i,
  output logic [mcpi_pkg::NUM_PORTS*4-1:0]          card_data_bus_o,
  output logic [mcpi_pkg::NUM_PORTS*4-1:0]          card_data_bus_oe_n,
  input  wire logic [mcpi_pkg::NUM_PORTS*4-1:0]     card_data_bus_i,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       card_present_n,
  input  wire logic [mcpi_pkg::NUM_PORTS-1:0]       write_protect_sense
);

  logic [mcpi_pkg::NUM_PORTS-1:0] present;
  logic [mcpi_pkg::NUM_PORTS-1:0] wprot;
  logic [mcpi_pkg::STAT_W-1:0]    stat_reg;
  logic [mcpi_pkg::STAT_W-1:0]    stat_next;

  // ----------------------------------------
  // Sockets
  // ----------------------------------------
  for (genvar i = 0; i < mcpi_pkg::NUM_PORTS; i++) begin : g_port // [R1]
    mcpi_port u_port (
      .ref_clk             (ref_clk),
      .rst                 (rst),
      .power_req           (power_req[i]),
      .wide_req            (wide_req[i]),
      .id_valid            (id_valid[i]),
      .id_type             (mcpi_pkg::mcpi_card_t'(id_type[2*i +: 2])),
      .sel_active          (sel_active[i]),
      .clk_half            (clk_half),
      .cmd_out             (cmd_out[i]),
      .cmd_drive           (cmd_drive[i]),
      .cmd_in              (cmd_in[i]),
      .data_out            (data_out[4*i +: 4]),
      .data_drive          (data_drive[i]),
      .data_in             (data_in[4*i +: 4]),
      .wide_active         (wide_active[i]),
      .present             (present[i]),
      .wprot               (wprot[i]),
      .card_clock_out      (card_clock_out[i]),
      .card_power_enable   (card_power_enable[i]),
      .card_cmd_line_o     (card_cmd_line_o[i]),
      .card_cmd_line_oe_n  (card_cmd_line_oe_n[i]),
      .card_cmd_line_i     (card_cmd_line_i[i]),
      .card_data_bus_o     (card_data_bus_o[4*i +: 4]),
      .card_data_bus_oe_n  (card_data_bus_oe_n[4*i +: 4]),
      .card_data_bus_i     (card_data_bus_i[4*i +: 4]),
      .card_present_n      (card_present_n[i]),
      .write_protect_sense (write_protect_sense[i])
    );
  end

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always_comb begin
    stat_next = '0;
    for (int j = 0; j < mcpi_pkg::NUM_PORTS; j++) begin
      stat_next[j*mcpi_pkg::STAT_BITS + mcpi_pkg::STAT_PRESENT_BIT]
        = present[j]; // [R7]
      stat_next[j*mcpi_pkg::STAT_BITS + mcpi_pkg::STAT_WPROT_BIT]
        = wprot[j];   // [R8]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_reg <= mcpi_pkg::STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign sys_card_status_reg = stat_reg;

  a_stat_present: assert property (@(posedge ref_clk) disable iff (rst)
    ##2 sys_card_status_reg[0] == !$past(card_present_n[0], 2))
    else $error("status presence wrong"); // [R7]
  a_stat_wprot: assert property (@(posedge ref_clk) disable iff (rst)
    ##2 sys_card_status_reg[3] == $past(write_protect_sense[1], 2))
    else $error("status write protect wrong"); // [R8]

endmodule // mcpi_top

// [sim/mcpi_card_model.sv]
// Card and socket model for one socket of the pin interface
`timescale 1ns/1ps
module mcpi_card_model (
  input  wire logic       inserted,
  input  wire logic       wp,
  input  wire logic       resp_cmd,
  input  wire logic [3:0] resp_data,
  input  wire logic       card_clock_out,
  input  wire logic       card_cmd_line_o,
  input  wire logic       card_cmd_line_oe_n,
  input  wire logic [3:0] card_data_bus_o,
  input  wire logic [3:0] card_data_bus_oe_n,
  output logic            card_cmd_line_i,
  output logic [3:0]      card_data_bus_i,
  output logic            card_present_n,
  output logic            write_protect_sense
);
  // ----------------------------------------
  // Socket switches and wire resolution
  // ----------------------------------------
  assign card_present_n      = ~inserted;
  assign write_protect_sense = inserted & wp;
  // Released lines carry the card response, or float to their pull-up level with no card
  assign card_cmd_line_i = !card_cmd_line_oe_n ? card_cmd_line_o
                         : (inserted ? resp_cmd : 1'b1);
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      card_data_bus_i[k] = !card_data_bus_oe_n[k] ? card_data_bus_o[k]
                         : (inserted ? resp_data[k] : 1'b1);
    end
  end
endmodule // mcpi_card_model

// [sim/tb_top.sv]
// Self-checking bench for the two-socket card pin interface
`timescale 1ns/1ps
module tb_top;
  logic       ref_clk = 1'b0, rst = 1'b1;
  logic [1:0] power_req = '0, wide_req = '0, id_valid = '0, sel_active = '0;
  logic [3:0] id_type = '0;
  logic [7:0] clk_half = 8'h01;
  logic [1:0] cmd_out = '0, cmd_drive = '0, data_drive = '0;
  logic [7:0] data_out = '0, resp_data = '0;
  logic [1:0] inserted = '0, wp = '0, resp_cmd = '0;
  logic [1:0] cmd_in, wide_active, clk_o, pwr_en, cmd_o, cmd_oe_n, cmd_i;
  logic [1:0] pres_n, wps;
  logic [7:0] data_in, dat_o, dat_oe_n, dat_i;
  logic [3:0] stat;
  int         failures = 0, comparisons = 0, cycles = 0;

  initial forever #10 ref_clk = ~ref_clk;

  mcpi_top dut_u (
    .ref_clk(ref_clk), .rst(rst), .power_req(power_req),
    .wide_req(wide_req), .id_valid(id_valid), .id_type(id_type),
    .sel_active(sel_active), .clk_half(clk_half), .cmd_out(cmd_out),
    .cmd_drive(cmd_drive), .cmd_in(cmd_in), .data_out(data_out),
    .data_drive(data_drive), .data_in(data_in), .wide_active(wide_active),
    .sys_card_status_reg(stat), .card_clock_out(clk_o),
    .card_power_enable(pwr_en), .card_cmd_line_o(cmd_o),
    .card_cmd_line_oe_n(cmd_oe_n), .card_cmd_line_i(cmd_i),
    .card_data_bus_o(dat_o), .card_data_bus_oe_n(dat_oe_n),
    .card_data_bus_i(dat_i), .card_present_n(pres_n),
    .write_protect_sense(wps));

  for (genvar i = 0; i < 2; i++) begin : g_card
    mcpi_card_model card_u (
      .inserted(inserted[i]), .wp(wp[i]), .resp_cmd(resp_cmd[i]),
      .resp_data(resp_data[4*i+:4]), .card_clock_out(clk_o[i]),
      .card_cmd_line_o(cmd_o[i]), .card_cmd_line_oe_n(cmd_oe_n[i]),
      .card_data_bus_o(dat_o[4*i+:4]), .card_data_bus_oe_n(dat_oe_n[4*i+:4]),
      .card_cmd_line_i(cmd_i[i]), .card_data_bus_i(dat_i[4*i+:4]),
      .card_present_n(pres_n[i]), .write_protect_sense(wps[i]));
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (exp !== got) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic end_sim();
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_mmc(input int i);
    power_req[i] = 1'b1;
    inserted[i]  = 1'b1;
    sel_active[i] = 1'b1;
    wait_cyc(4);
    chk("power", 8'h01, pwr_en[i]);
    chk("present", 8'h01, stat[2*i]);
    chk("other power", {7'h00, power_req[1-i]}, pwr_en[1-i]);
    chk("narrow", 8'h00, wide_active[i]);
    data_drive[i] = 1'b1;
    data_out[4*i+:4] = 4'hF;
    wait_cyc(1);
    chk("mmc oe_n", 8'h06, dat_oe_n[4*i+:4]);
    chk("select", 8'h00, dat_o[4*i+3]);
    data_drive[i] = 1'b0;
    resp_data[4*i+:4] = 4'hF;
    wait_cyc(1);
    chk("mmc data_in", 8'h01, data_in[4*i+:4]);
  endtask

  task automatic t_clk_cmd(input int i);
    int tog;
    logic last;
    tog = 0;
    last = clk_o[i];
    repeat (40) begin
      @(negedge ref_clk);
      if (clk_o[i] !== last) tog++;
      last = clk_o[i];
    end
    chk("clock toggles", 8'h01, 8'(tog >= 19 && tog <= 20));
    cmd_drive[i] = 1'b1;
    cmd_out[i] = 1'b1;
    wait_cyc(1);
    chk("cmd drive", 8'h01, {cmd_oe_n[i], cmd_o[i]});
    cmd_drive[i] = 1'b0;
    resp_cmd[i] = 1'b0;
    wait_cyc(1);
    chk("cmd oe_n", 8'h01, cmd_oe_n[i]);
    chk("cmd response", 8'h00, cmd_in[i]);
  endtask

  task automatic t_wide(input int i, input logic [1:0] kind);
    id_type[2*i+:2] = kind;
    id_valid[i] = 1'b1;
    wait_cyc(1);
    id_valid[i] = 1'b0;
    wait_cyc(1);
    wide_req[i] = 1'b1;
    wait_cyc(2);
    chk("wide", {7'h00, kind == 2'h2}, wide_active[i]);
    data_drive[i] = 1'b1;
    wait_cyc(1);
    chk("bus oe_n", kind == 2'h2 ? 8'h00 : 8'h06,
        dat_oe_n[4*i+:4]);
    chk("bus out", kind == 2'h2 ? 8'h0F : 8'h01,
        dat_o[4*i+:4]);
    data_drive[i] = 1'b0;
    resp_data[4*i+:4] = 4'hA;
    wait_cyc(1);
    chk("bus in", kind == 2'h2 ? 8'h0A : 8'h00,
        data_in[4*i+:4]);
  endtask

  task automatic t_wp_remove(input int i);
    wp[i] = 1'b1;
    wait_cyc(3);
    chk("wprot set", 8'h01, stat[2*i+1]);
    wp[i] = 1'b0;
    wait_cyc(3);
    chk("wprot clear", 8'h00, stat[2*i+1]);
    inserted[i] = 1'b0;
    wait_cyc(3);
    chk("removed", 8'h00, stat[2*i]);
    chk("mode idle", 8'h00, wide_active[i]);
    inserted[i] = 1'b1;
    wait_cyc(3);
    chk("reinserted narrow", 8'h00, wide_active[i]);
    power_req[i] = 1'b0;
    wait_cyc(2);
    chk("power off", 8'h00, pwr_en[i]);
  endtask

  // ----------------------------------------
  // Main sequence and timeout
  // ----------------------------------------
  initial begin
    wait_cyc(10);
    rst = 1'b0;
    t_power_mmc(0);
    t_clk_cmd(0);
    t_wide(0, 2'h1);
    t_power_mmc(1);
    t_clk_cmd(1);
    t_wide(1, 2'h2);
    t_wp_remove(1);
    t_wp_remove(0);
    end_sim();
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      end_sim();
    end
  end
endmodule // tb_top
